/* rtl/cssl_top.sv */
// Card socket support logic: power switch control word, link select latch,
// audio routing, status-change pull select and socket activity LEDs.
// Assumes all inputs synchronous to CLK; the 16 kHz tick is made internally.
// LED timing and oscillator counts are parameters so a bench can shorten them.
//
// Notes on behaviour
// - Sample link select pin at reset release
// - Bit ten picks switch family, default first
// - First family programming supply encoding
// - Core supply encoding for both families
// - Second family programming supply encoding
// - Internal 16 kHz tick always runs
// - Pull-up for 16-bit, pull-down CardBus
// - Speaker output gated by enable bit
// - Battery detect two is card speaker
// - Audio route bit sends PWM out
// - LED high 64 ms after activity
// - LED only when card inserted, powered, running
// - 16-bit: ready low is activity
// - CardBus: frame, irdy, request are activity
// - LED forced off in suspend, clkrun, D1/D2
// - New activity restarts LED period
// - 1.8 V card sets 3 V or X.X V flag
`default_nettype none
module cssl_top
    import cssl_pkg::*;
#(
    parameter int unsigned LED_PERIOD = LED_TICKS,
    parameter int unsigned OSC_HALF   = OSC_HALF_CYC
) (
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 SWITCH_LINK_SELECT_PIN,
    input  wire logic                 SWITCH_TYPE_SELECT,
    input  wire logic                 POWER_ENABLE,
    input  wire cssl_slot_req_t       SLOT_A_REQ,
    input  wire cssl_slot_req_t       SLOT_B_REQ,
    input  wire logic                 SPEAKER_OUT_ENABLE,
    input  wire logic                 AUDIO_PWM_ROUTE,
    input  wire logic                 BATTERY_DETECT_TWO,
    input  wire cssl_card_t           CARD,
    input  wire cssl_activity_t       ACTIVITY,
    input  wire cssl_power_t          POWER_STATE,
    input  wire logic                 CARD_1V8_DETECTED,
    output logic                      SERIAL_LINK_SEL,
    output logic [SW_WORD_W-1:0]      SWITCH_WORD,
    output logic                      OSC_TICK,
    output logic                      STATUS_PULL_UP,
    output logic                      STATUS_PULL_DOWN,
    output logic                      SPEAKER_OUT,
    output logic                      AUDIO_PWM_OUT,
    output logic                      ACTIVITY_LED_A,
    output logic                      ACTIVITY_LED_SOCKET,
    output logic                      LOW_VOLT_CARD_FLAG,
    output logic                      EXTRA_VOLT_CARD_FLAG
);

    // ----------------------------------------------------------------
    // Encoding functions
    // ----------------------------------------------------------------
    // Returns {pp2, pp1, pp0}
    // Family one: 10x and 110 Hi-Z, 111 core 1.8 V; 12 V falls to Hi-Z
    // Family two: 10x 12 V, 11x Hi-Z; 1.8 V falls to Hi-Z
    function automatic logic [2:0] enc_vpp(input cssl_vpp_t v, input logic fam2);
        logic [2:0] e;
        e = 3'h4;
        case (v)
            CSSL_PP_0V:  e = 3'h0;
            CSSL_PP_3V3: e = 3'h2;
            CSSL_PP_5V:  e = 3'h6;
            CSSL_PP_12V: e = fam2 ? 3'h1 : 3'h1;
            CSSL_PP_1V8: e = fam2 ? 3'h3 : 3'h7;
            CSSL_PP_HIZ: e = fam2 ? 3'h3 : 3'h1;
            default:     e = 3'h1;
        endcase
        return e;
    endfunction

    // Returns {hi, lo}: 01 = 3.3 V, 10 = 5 V, 00 = 0 V
    // Code 11 is 0 V for both families; it is never generated
    function automatic logic [1:0] enc_vcc(input cssl_vcc_t v);
        logic [1:0] e;
        e = 2'h0;
        case (v)
            CSSL_CC_3V3: e = 2'h1;
            CSSL_CC_5V:  e = 2'h2;
            default:     e = 2'h0;
        endcase
        return e;
    endfunction

    // ----------------------------------------------------------------
    // Link select latch
    // ----------------------------------------------------------------
    logic rst_d_r;
    logic rst_done;
    logic link_serial_r;
    logic link_serial_nxt;

    // Strap is taken once, in the first cycle after reset ends, so the
    // link type cannot change while the switch is being driven
    assign rst_done        = rst_d_r && !RST;
    assign link_serial_nxt = rst_done ? SWITCH_LINK_SELECT_PIN : link_serial_r;

    always_ff @(posedge CLK) begin
        rst_d_r <= RST;
    end

    // Not reset: it must survive into the cycle after release
    always_ff @(posedge CLK) begin
        link_serial_r <= link_serial_nxt;
    end

    assign SERIAL_LINK_SEL = link_serial_r;

    // ----------------------------------------------------------------
    // Switch control word
    // ----------------------------------------------------------------
    logic              fam2;
    logic [2:0]        a_pp;
    logic [2:0]        b_pp;
    logic [1:0]        a_cc;
    logic [1:0]        b_cc;
    logic [SW_WORD_W-1:0] word_nxt;
    logic [SW_WORD_W-1:0] word_r;

    assign fam2 = SWITCH_TYPE_SELECT;
    assign a_pp = enc_vpp(SLOT_A_REQ.vpp, fam2);
    assign b_pp = enc_vpp(SLOT_B_REQ.vpp, fam2);
    assign a_cc = enc_vcc(SLOT_A_REQ.vcc);
    assign b_cc = enc_vcc(SLOT_B_REQ.vcc);

    // Shutdown bit follows power enable so a disabled socket sees Hi-Z outputs
    always_comb begin
        word_nxt              = SW_WORD_RST;
        word_nxt[SW_A_PP0]    = a_pp[0];
        word_nxt[SW_A_PP1]    = a_pp[1];
        word_nxt[SW_A_PP2]    = a_pp[2];
        word_nxt[SW_B_PP0]    = b_pp[0];
        word_nxt[SW_B_PP1]    = b_pp[1];
        word_nxt[SW_B_PP2]    = b_pp[2];
        word_nxt[SW_A_CC_LO]  = a_cc[0];
        word_nxt[SW_A_CC_HI]  = a_cc[1];
        word_nxt[SW_B_CC_LO]  = b_cc[0];
        word_nxt[SW_B_CC_HI]  = b_cc[1];
        word_nxt[SW_SWITCH_SHUTDOWN_N_BIT] = POWER_ENABLE;
    end

    // Registered so the switch never sees decode glitches
    always_ff @(posedge CLK) begin
        if (RST) begin
            word_r <= SW_WORD_RST;
        end else begin
            word_r <= word_nxt;
        end
    end

    assign SWITCH_WORD = word_r;

    // ----------------------------------------------------------------
    // Internal oscillator tick
    // ----------------------------------------------------------------
    localparam int unsigned OSC_W = $clog2(OSC_HALF * 2 + 1);
    // Counter sized to hold a full oscillator period
    logic [OSC_W-1:0] osc_cnt_r;
    logic [OSC_W-1:0] osc_cnt_nxt;
    logic             osc_wrap;
    logic             tick_r;

    assign osc_wrap    = (osc_cnt_r == OSC_W'(OSC_HALF * 2 - 1));
    assign osc_cnt_nxt = osc_wrap ? '0 : osc_cnt_r + 1'b1;

    // Free running, never gated by power state or card state
    always_ff @(posedge CLK) begin
        if (RST) begin
            osc_cnt_r <= '0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
        end
    end

    // One-cycle pulse per oscillator period
    always_ff @(posedge CLK) begin
        if (RST) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= osc_wrap;
        end
    end

    assign OSC_TICK = tick_r;

    // ----------------------------------------------------------------
    // Status change pull, audio routing, voltage flags
    // ----------------------------------------------------------------
    logic pull_up_r;
    logic pull_up_nxt;
    logic pull_dn_r;
    logic pull_dn_nxt;
    logic card_speaker_in_r;
    logic card_speaker_in_nxt;
    logic pwm_r;
    logic pwm_nxt;
    logic lv_r;
    logic lv_nxt;
    logic xv_r;
    logic xv_nxt;

    logic audio_in;
    logic audio_valid;
    logic cb_present;
    logic pwm_takes;

    assign audio_in    = BATTERY_DETECT_TWO;
    // Audio passes only for an I/O-mode 16-bit card or a CardBus card
    assign audio_valid = CARD.card_present && (CARD.is_cardbus || CARD.io_mode);
    assign cb_present  = CARD.card_present && CARD.is_cardbus;
    // With the route bit set a CardBus card's audio leaves only on the PWM output
    assign pwm_takes   = AUDIO_PWM_ROUTE && CARD.is_cardbus;
    // An empty socket keeps the pull-up, matching the reset state
    assign pull_up_nxt = !cb_present;
    assign pull_dn_nxt = cb_present;
    assign card_speaker_in_nxt    = SPEAKER_OUT_ENABLE && audio_valid && audio_in && !pwm_takes;
    assign pwm_nxt     = AUDIO_PWM_ROUTE && cb_present && audio_in;
    assign lv_nxt      = CARD_1V8_DETECTED && !fam2;
    assign xv_nxt      = CARD_1V8_DETECTED && fam2;

    // Pin-facing outputs are registered to keep them glitch free
    always_ff @(posedge CLK) begin
        if (RST) begin
            pull_up_r <= 1'b1;
        end else begin
            pull_up_r <= pull_up_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pull_dn_r <= 1'b0;
        end else begin
            pull_dn_r <= pull_dn_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            card_speaker_in_r <= 1'b0;
        end else begin
            card_speaker_in_r <= card_speaker_in_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= pwm_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            lv_r <= 1'b0;
        end else begin
            lv_r <= lv_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            xv_r <= 1'b0;
        end else begin
            xv_r <= xv_nxt;
        end
    end

    assign STATUS_PULL_UP       = pull_up_r;
    assign STATUS_PULL_DOWN     = pull_dn_r;
    assign SPEAKER_OUT          = card_speaker_in_r;
    assign AUDIO_PWM_OUT        = pwm_r;
    assign LOW_VOLT_CARD_FLAG   = lv_r;
    assign EXTRA_VOLT_CARD_FLAG = xv_r;

    // ----------------------------------------------------------------
    // Activity LED timer
    // ----------------------------------------------------------------
    localparam int unsigned LED_W = $clog2(LED_PERIOD + 1);
    logic [LED_W-1:0] led_cnt_r;
    logic [LED_W-1:0] led_cnt_nxt;
    logic             card_live;
    logic             led_block;
    logic             act_cb;
    logic             act_16;
    logic             act_hit;
    logic             led_nxt;
    logic             led_r;

    assign card_live = CARD.card_present && CARD.card_powered && !CARD.card_in_reset;
    assign led_block = POWER_STATE.suspend || POWER_STATE.clkrun_stop
                       || POWER_STATE.d1_d2;
    assign act_cb    = !ACTIVITY.frame_n || !ACTIVITY.irdy_n || !ACTIVITY.bus_req_n;
    assign act_16    = !ACTIVITY.ready_irq_n;
    assign act_hit   = card_live && (CARD.is_cardbus ? act_cb : act_16);
    // Blocking only masks the output; the count goes on so the LED
    // cannot come back stuck on when the bus clock returns
    assign led_nxt   = (led_cnt_nxt != '0) && !led_block;

    // Activity reloads, oscillator ticks count down, a dead card clears

    always_comb begin
        led_cnt_nxt = led_cnt_r;
        if (!card_live) begin
            led_cnt_nxt = '0;
        end else if (act_hit) begin
            led_cnt_nxt = LED_W'(LED_PERIOD);
        end else if (tick_r && led_cnt_r != '0) begin
            led_cnt_nxt = led_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            led_cnt_r <= '0;
        end else begin
            led_cnt_r <= led_cnt_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            led_r <= 1'b0;
        end else begin
            led_r <= led_nxt;
        end
    end

    assign ACTIVITY_LED_A      = led_r;
    assign ACTIVITY_LED_SOCKET = led_r;

endmodule
`default_nettype wire

/* common/cssl_pkg.sv */
// Package for the card socket support logic: timing counts, switch control
// word layout, supply and link enumerations, grouped port structs.
// Assumes a single 10 MHz clock domain.
`default_nettype none
package cssl_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned OSC_HZ        = 16_000;
    localparam int unsigned LED_TIME_MS   = 64;
    // Oscillator half period in system clocks (longest time, round down)
    localparam int unsigned OSC_HALF_CYC  = CLK_HZ / (2 * OSC_HZ);
    // LED period in oscillator ticks
    localparam int unsigned LED_TICKS     = (LED_TIME_MS * OSC_HZ) / 1000;

    // ----------------------------------------------------------------
    // Switch control word bit positions
    // ----------------------------------------------------------------
    localparam int unsigned SW_WORD_W     = 11;
    localparam int unsigned SW_A_PP0      = 0;
    localparam int unsigned SW_A_PP1      = 1;
    localparam int unsigned SW_A_CC_LO    = 2;
    localparam int unsigned SW_A_CC_HI    = 3;
    localparam int unsigned SW_B_PP0      = 4;
    localparam int unsigned SW_B_PP1      = 5;
    localparam int unsigned SW_B_CC_HI    = 6;
    localparam int unsigned SW_B_CC_LO    = 7;
    localparam int unsigned SW_SWITCH_SHUTDOWN_N_BIT   = 8;
    localparam int unsigned SW_A_PP2      = 9;
    localparam int unsigned SW_B_PP2      = 10;
    localparam logic [10:0] SW_WORD_RST   = 11'h000;

    // ----------------------------------------------------------------
    // Register bit positions (carried as ports)
    // ----------------------------------------------------------------
    localparam int unsigned GEN_CTRL_SWSEL_BIT  = 10;
    localparam int unsigned CARD_CTRL_CARD_SPEAKER_IN_BIT  = 1;
    localparam int unsigned CARD_CTRL_AUD2_BIT  = 2;
    localparam logic        SWITCH_TYPE_RST     = 1'b0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CSSL_PP_0V, CSSL_PP_3V3, CSSL_PP_5V, CSSL_PP_12V, CSSL_PP_1V8, CSSL_PP_HIZ
    } cssl_vpp_t;

    typedef enum logic [1:0] {
        CSSL_CC_0V, CSSL_CC_3V3, CSSL_CC_5V
    } cssl_vcc_t;

    typedef enum logic {
        CSSL_LINK_PARALLEL, CSSL_LINK_SERIAL
    } cssl_link_t;

    typedef struct packed {
        cssl_vpp_t vpp;
        cssl_vcc_t vcc;
    } cssl_slot_req_t;

    typedef struct packed {
        logic card_present;
        logic card_powered;
        logic card_in_reset;
        logic is_cardbus;
        logic io_mode;
    } cssl_card_t;

    typedef struct packed {
        logic ready_irq_n;
        logic frame_n;
        logic irdy_n;
        logic bus_req_n;
    } cssl_activity_t;

    typedef struct packed {
        logic suspend;
        logic clkrun_stop;
        logic d1_d2;
    } cssl_power_t;

endpackage
`default_nettype wire

/* tb/cssl_monitor.sv */
// Checker of the socket support block, bound to its top module.
// Assumes one clock, synchronous reset and an oscillator half period of two clocks.
`default_nettype none
module cssl_monitor
    import cssl_pkg::*;
(
    input wire logic                 CLK,
    input wire logic                 RST,
    input wire logic                 SWITCH_LINK_SELECT_PIN,
    input wire logic                 SERIAL_LINK_SEL,
    input wire logic                 POWER_ENABLE,
    input wire logic [SW_WORD_W-1:0] SWITCH_WORD,
    input wire logic                 SPEAKER_OUT_ENABLE,
    input wire logic                 SPEAKER_OUT,
    input wire logic                 AUDIO_PWM_ROUTE,
    input wire logic                 BATTERY_DETECT_TWO,
    input wire logic                 AUDIO_PWM_OUT,
    input wire cssl_card_t           CARD,
    input wire cssl_activity_t       ACTIVITY,
    input wire cssl_power_t          POWER_STATE,
    input wire logic                 ACTIVITY_LED_A,
    input wire logic                 ACTIVITY_LED_SOCKET,
    input wire logic                 OSC_TICK
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    wire logic live = CARD.card_present && CARD.card_powered && !CARD.card_in_reset;

    chk_link_load: assert property ($fell(RST) |=> SERIAL_LINK_SEL == $past(SWITCH_LINK_SELECT_PIN))
        else $error("link select not loaded at reset release");
    chk_link_hold: assert property (!$past(RST) && !$past(RST, 2) |-> $stable(SERIAL_LINK_SEL))
        else $error("link select changed in operation");
    chk_shutdown_hiz: assert property (!POWER_ENABLE |=> !SWITCH_WORD[SW_SWITCH_SHUTDOWN_N_BIT])
        else $error("shutdown bit high with power off");
    chk_speaker_gate: assert property (!SPEAKER_OUT_ENABLE |=> !SPEAKER_OUT)
        else $error("speaker driven while disabled");
    chk_pwm_route: assert property (AUDIO_PWM_ROUTE && CARD.is_cardbus && CARD.card_present
        |=> AUDIO_PWM_OUT == $past(BATTERY_DETECT_TWO) && !SPEAKER_OUT)
        else $error("audio not routed to pwm output");
    chk_led_live: assert property (!live |=> !ACTIVITY_LED_A)
        else $error("led lit without live card");
    chk_led_quiet: assert property (POWER_STATE != 3'h0 |=> !ACTIVITY_LED_A)
        else $error("led lit in low power state");
    chk_led_frame: assert property (live && CARD.is_cardbus && !ACTIVITY.frame_n
        && POWER_STATE == 3'h0 |=> ACTIVITY_LED_A)
        else $error("led not lit on frame activity");
    chk_led_pair: assert property (ACTIVITY_LED_A == ACTIVITY_LED_SOCKET)
        else $error("led outputs differ");
    chk_tick_gap: assert property (OSC_TICK |=> !OSC_TICK [*3] ##1 OSC_TICK)
        else $error("oscillator tick period wrong");
endmodule
`default_nettype wire

/* tb/cssl_switch_model.sv */
// Behavioural model of the external socket power switch chip.
// Assumes the control word arrives whole; family chosen by a strap input.
`default_nettype none
module cssl_switch_model
    import cssl_pkg::*;
(
    input  wire logic [SW_WORD_W-1:0] word,
    input  wire logic                 family,
    output var  cssl_vpp_t            a_vpp,
    output var  cssl_vpp_t            b_vpp,
    output var  cssl_vcc_t            a_vcc,
    output var  cssl_vcc_t            b_vcc,
    output logic                      vcc_off
);
    // ----------------------------------------------------------------
    // Output decode
    // ----------------------------------------------------------------
    function automatic cssl_vpp_t vpp_of(input logic fam, input logic [2:0] c);
        case ({fam, c}) inside
            4'b000?, 4'b100?: return CSSL_PP_0V;
            4'b0010, 4'b1010: return CSSL_PP_3V3;
            4'b0011, 4'b1011: return CSSL_PP_5V;
            4'b0111:          return CSSL_PP_1V8;
            4'b110?:          return CSSL_PP_12V;
            default:          return CSSL_PP_HIZ;
        endcase
    endfunction

    function automatic cssl_vcc_t vcc_of(input logic [1:0] c);
        return (c == 2'h3) ? CSSL_CC_0V : cssl_vcc_t'(c);
    endfunction

    assign a_vpp   = word[8] ? vpp_of(family, {word[0], word[1], word[9]}) : CSSL_PP_HIZ;
    assign b_vpp   = word[8] ? vpp_of(family, {word[4], word[5], word[10]}) : CSSL_PP_HIZ;
    assign a_vcc   = vcc_of({word[3], word[2]});
    assign b_vcc   = vcc_of({word[6], word[7]});
    assign vcc_off = !word[8];
endmodule
`default_nettype wire

/* tb/test_cssl_top.sv */
// Self-checking bench of the socket support block with a power switch model.
// Assumes short counts: four ticks per LED period, one tick every four clocks.
`default_nettype none
module test_cssl_top
    import cssl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam int LED_P = 4;
    typedef struct packed {logic f; logic p; cssl_vpp_t rq; cssl_vcc_t cc; cssl_vpp_t ex;} cssl_row_t;
    logic CLK = 1'b0, RST = 1'b1, SWITCH_LINK_SELECT_PIN = 1'b1, SWITCH_TYPE_SELECT = 1'b0;
    logic POWER_ENABLE = 1'b0, SPEAKER_OUT_ENABLE = 1'b0, AUDIO_PWM_ROUTE = 1'b0;
    logic BATTERY_DETECT_TWO = 1'b0, CARD_1V8_DETECTED = 1'b0;
    cssl_slot_req_t SLOT_A_REQ = 5'h00, SLOT_B_REQ = 5'h00;
    cssl_card_t CARD = 5'h00;
    cssl_activity_t ACTIVITY = 4'hF;
    cssl_power_t POWER_STATE = 3'h0;
    logic SERIAL_LINK_SEL, OSC_TICK, STATUS_PULL_UP, STATUS_PULL_DOWN, SPEAKER_OUT, vcc_off;
    logic AUDIO_PWM_OUT, ACTIVITY_LED_A, ACTIVITY_LED_SOCKET, LOW_VOLT_CARD_FLAG, EXTRA_VOLT_CARD_FLAG;
    logic [SW_WORD_W-1:0] SWITCH_WORD;
    cssl_vpp_t a_vpp, b_vpp;
    cssl_vcc_t a_vcc, b_vcc;
    int failures = 0, n_checks = 0;
    cssl_row_t rows [13] = '{
        '{1'h0, 1'h1, CSSL_PP_0V, CSSL_CC_3V3, CSSL_PP_0V}, '{1'h0, 1'h1, CSSL_PP_3V3, CSSL_CC_5V, CSSL_PP_3V3},
        '{1'h0, 1'h1, CSSL_PP_5V, CSSL_CC_0V, CSSL_PP_5V}, '{1'h0, 1'h1, CSSL_PP_12V, CSSL_CC_3V3, CSSL_PP_HIZ},
        '{1'h0, 1'h1, CSSL_PP_1V8, CSSL_CC_5V, CSSL_PP_1V8}, '{1'h0, 1'h1, CSSL_PP_HIZ, CSSL_CC_0V, CSSL_PP_HIZ},
        '{1'h1, 1'h1, CSSL_PP_0V, CSSL_CC_5V, CSSL_PP_0V}, '{1'h1, 1'h1, CSSL_PP_3V3, CSSL_CC_0V, CSSL_PP_3V3},
        '{1'h1, 1'h1, CSSL_PP_5V, CSSL_CC_3V3, CSSL_PP_5V}, '{1'h1, 1'h1, CSSL_PP_12V, CSSL_CC_5V, CSSL_PP_12V},
        '{1'h1, 1'h1, CSSL_PP_1V8, CSSL_CC_0V, CSSL_PP_HIZ}, '{1'h1, 1'h1, CSSL_PP_HIZ, CSSL_CC_3V3, CSSL_PP_HIZ},
        '{1'h1, 1'h0, CSSL_PP_5V, CSSL_CC_5V, CSSL_PP_HIZ}};

    cssl_top #(.LED_PERIOD(LED_P), .OSC_HALF(2)) cssl_top_i (.CLK, .RST, .SWITCH_LINK_SELECT_PIN,
        .SWITCH_TYPE_SELECT, .POWER_ENABLE, .SLOT_A_REQ, .SLOT_B_REQ, .SPEAKER_OUT_ENABLE,
        .AUDIO_PWM_ROUTE, .BATTERY_DETECT_TWO, .CARD, .ACTIVITY, .POWER_STATE, .CARD_1V8_DETECTED,
        .SERIAL_LINK_SEL, .SWITCH_WORD, .OSC_TICK, .STATUS_PULL_UP, .STATUS_PULL_DOWN, .SPEAKER_OUT,
        .AUDIO_PWM_OUT, .ACTIVITY_LED_A, .ACTIVITY_LED_SOCKET, .LOW_VOLT_CARD_FLAG, .EXTRA_VOLT_CARD_FLAG);
    cssl_switch_model cssl_switch_model_i (.word(SWITCH_WORD), .family(SWITCH_TYPE_SELECT), .a_vpp,
        .b_vpp, .a_vcc, .b_vcc, .vcc_off);

    always #50 CLK = ~CLK;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic pin);
        @(posedge CLK);
        RST <= 1'b1;
        SWITCH_LINK_SELECT_PIN <= pin;
        settle(16);
        chk("word in reset", SWITCH_WORD, 16'h0000);
        @(posedge CLK);
        RST <= 1'b0;
        settle(2);
        chk("link select", SERIAL_LINK_SEL, pin);
        @(posedge CLK);
        SWITCH_LINK_SELECT_PIN <= ~pin;
        settle(2);
        chk("link held", SERIAL_LINK_SEL, pin);
    endtask

    // Activity pulse, optional retrigger after gap cycles, then ticks counted until dark
    task automatic led_run(input cssl_activity_t a, input int gap);
        int n;
        n = 0;
        @(posedge CLK);
        ACTIVITY <= a;
        settle(1);
        chk("led on", {ACTIVITY_LED_A, ACTIVITY_LED_SOCKET}, 16'h3);
        @(posedge CLK);
        ACTIVITY <= 4'hF;
        if (gap > 0) begin
            settle(gap);
            chk("led held", ACTIVITY_LED_A, 16'h1);
            @(posedge CLK);
            ACTIVITY <= a;
            @(posedge CLK);
            ACTIVITY <= 4'hF;
        end
        while (ACTIVITY_LED_A === 1'b1 && n < 100) begin
            @(negedge CLK);
            n += int'(OSC_TICK);
        end
        chk("led ticks", 16'(n >= LED_P - 1 && n <= LED_P + 1), 16'h1);
    endtask

    initial begin
        do_reset(1'b1);
        foreach (rows[i]) begin
            @(posedge CLK);
            SWITCH_TYPE_SELECT <= rows[i].f;
            POWER_ENABLE <= rows[i].p;
            SLOT_A_REQ <= '{rows[i].rq, rows[i].cc};
            SLOT_B_REQ <= '{rows[i].rq, rows[i].cc};
            settle(1);
            chk("vpp", {a_vpp, b_vpp}, {rows[i].ex, rows[i].ex});
            chk("vcc", {vcc_off, a_vcc, b_vcc}, {!rows[i].p, rows[i].cc, rows[i].cc});
        end
        @(posedge CLK);
        CARD <= 5'h18;
        SPEAKER_OUT_ENABLE <= 1'b1;
        BATTERY_DETECT_TWO <= 1'b1;
        settle(1);
        chk("speaker no io", SPEAKER_OUT, 16'h0);
        @(posedge CLK);
        CARD <= 5'h19;
        SPEAKER_OUT_ENABLE <= 1'b1;
        BATTERY_DETECT_TWO <= 1'b1;
        CARD_1V8_DETECTED <= 1'b1;
        SWITCH_TYPE_SELECT <= 1'b0;
        settle(1);
        chk("speaker", SPEAKER_OUT, 16'h1);
        chk("pull", {STATUS_PULL_UP, STATUS_PULL_DOWN}, 16'h2);
        chk("flags", {LOW_VOLT_CARD_FLAG, EXTRA_VOLT_CARD_FLAG}, 16'h2);
        led_run(4'h7, 0);
        @(posedge CLK);
        CARD <= 5'h1A;
        AUDIO_PWM_ROUTE <= 1'b1;
        SWITCH_TYPE_SELECT <= 1'b1;
        settle(1);
        chk("pwm", {AUDIO_PWM_OUT, SPEAKER_OUT}, 16'h2);
        chk("pull", {STATUS_PULL_UP, STATUS_PULL_DOWN}, 16'h1);
        chk("flags", {LOW_VOLT_CARD_FLAG, EXTRA_VOLT_CARD_FLAG}, 16'h1);
        led_run(4'hB, 8);
        led_run(4'hD, 0);
        led_run(4'hE, 0);
        @(posedge CLK);
        SPEAKER_OUT_ENABLE <= 1'b0;
        AUDIO_PWM_ROUTE <= 1'b0;
        POWER_STATE <= 3'h4;
        ACTIVITY <= 4'hB;
        settle(1);
        chk("speaker off", {SPEAKER_OUT, AUDIO_PWM_OUT}, 16'h0);
        chk("led quiet", ACTIVITY_LED_A, 16'h0);
        @(posedge CLK);
        POWER_STATE <= 3'h0;
        CARD <= 5'h1E;
        settle(2);
        chk("led dead card", ACTIVITY_LED_A, 16'h0);
        @(posedge CLK);
        ACTIVITY <= 4'hF;
        do_reset(1'b0);
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge CLK);
        failures++;
        end_of_test();
    end
endmodule

bind cssl_top cssl_monitor cssl_monitor_i (.CLK, .RST, .SWITCH_LINK_SELECT_PIN, .SERIAL_LINK_SEL,
    .POWER_ENABLE, .SWITCH_WORD, .SPEAKER_OUT_ENABLE, .SPEAKER_OUT, .AUDIO_PWM_ROUTE,
    .BATTERY_DETECT_TWO, .AUDIO_PWM_OUT, .CARD, .ACTIVITY, .POWER_STATE, .ACTIVITY_LED_A,
    .ACTIVITY_LED_SOCKET, .OSC_TICK);
`default_nettype wire
